/* File: rtl/smbirq_pkg.sv */
// constants shared by the bus interrupt status and enable block
package smbirq_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] SMBIRQ_ADDR_STATUS   = 8'h80;
  localparam logic [7:0] SMBIRQ_ADDR_ENABLE   = 8'h81;
  localparam logic [7:0] SMBIRQ_ADDR_EVT_CAP  = 8'h84;
  localparam logic [7:0] SMBIRQ_ADDR_EVT_MASK = 8'h85;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SMBIRQ_RST_STATUS    = 8'h00;
  localparam logic [7:0] SMBIRQ_RST_ENABLE    = 8'h00;
  localparam logic [7:0] SMBIRQ_RST_EVT_CAP   = 8'h00;
  localparam logic [7:0] SMBIRQ_RST_EVT_MASK  = 8'h00;

  // ---------------------------------------------------------------
  // bit positions, shared by status, enable, capture and mask
  // ---------------------------------------------------------------
  localparam int SMBIRQ_BIT_PEND  = 0;
  localparam int SMBIRQ_BIT_ERR   = 1;
  localparam int SMBIRQ_BIT_COL   = 2;
  localparam int SMBIRQ_BIT_DONE  = 3;
  localparam int SMBIRQ_BIT_CHUNK = 4;
  localparam int SMBIRQ_BIT_SLAVE = 5;
  localparam int SMBIRQ_BIT_ALIAS = 6;
  localparam int SMBIRQ_BIT_ALERT = 7;

  // ---------------------------------------------------------------
  // counts and fixed values
  // ---------------------------------------------------------------
  localparam int         SMBIRQ_CHUNK_BYTES = 8;
  localparam logic [6:0] SMBIRQ_SLAVE_ADDR  = 7'h10;
  localparam logic       SMBIRQ_ALERT_IDLE  = 1'b1;

endpackage

/* File: rtl/smbirq_sync.sv */
// two flip-flop synchroniser for levels arriving from pins
`timescale 1ns/10ps
module smbirq_sync #(
  parameter int         WIDTH     = 1,
  parameter logic [0:0] RESET_VAL = 1'b0
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // the first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_r   <= {WIDTH{RESET_VAL}};
      sync_out <= {WIDTH{RESET_VAL}};
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // smbirq_sync

/* File: rtl/smbirq_chunk_cnt.sv */
// byte counter that pulses once per completed group of bytes
`timescale 1ns/10ps
module smbirq_chunk_cnt #(
  parameter int CHUNK = 8
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic clr,
  input  wire logic step,
  output logic      chunk_pulse
);

  localparam int CW = $clog2(CHUNK);
  localparam logic [CW-1:0] LAST = CW'(CHUNK - 1);

  logic [CW-1:0] cnt_r;

  // clear wins over a step, a new transfer always starts at zero
  always_ff @(posedge core_clk) begin
    if (srst || clr) begin
      cnt_r <= '0;
    end else if (step) begin
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || clr) begin
      chunk_pulse <= 1'b0;
    end else begin
      chunk_pulse <= step && (cnt_r == LAST);
    end
  end

endmodule // smbirq_chunk_cnt

/* File: rtl/smbirq_top.sv */
// interrupt status and enable logic of the bus host controller
`timescale 1ns/10ps
module smbirq_top
  import smbirq_pkg::*;
#(
  parameter int CHUNK = SMBIRQ_CHUNK_BYTES
) (
  input  wire logic       core_clk,
  input  wire logic       srst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // alert pin, active low, asynchronous
  input  wire logic       smbus_alert_n,
  // events from the host master engine
  input  wire logic       host_lost_arb,
  input  wire logic       host_unclaimed,
  input  wire logic       host_slave_timeout,
  input  wire logic       host_start,
  input  wire logic       host_block_mode,
  input  wire logic       host_byte_done,
  input  wire logic       host_done,
  // events from the host slave engine
  input  wire logic       slave_master_timeout,
  input  wire logic       slave_write_word,
  input  wire logic [6:0] slave_dev_addr,
  input  wire logic [6:0] alias_addr,
  // outputs
  output logic            slave_hold,
  output logic            smb_irq,
  output logic            evt_irq
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic       alert_n_sync;
  logic       alert_act;
  logic       chunk_evt;
  logic       alias_hit;
  logic       slave_hit;
  logic       wr_status;
  logic       wr_enable;
  logic       wr_mask;
  logic       rd_cap;
  logic [7:0] clr_mask;
  logic [7:0] evt_set;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] enable_r;
  logic [7:0] cap_r;
  logic [7:0] cap_nxt;
  logic [7:0] mask_r;
  logic       pending;
  logic [7:0] status_view;
  logic [7:0] rdata_nxt;

  // ---------------------------------------------------------------
  // alert pin crossing
  // ---------------------------------------------------------------
  smbirq_sync #(
    .WIDTH     (1),
    .RESET_VAL (SMBIRQ_ALERT_IDLE)
  ) u_alert_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in (smbus_alert_n),
    .sync_out (alert_n_sync)
  );

  assign alert_act = ~alert_n_sync;

  // ---------------------------------------------------------------
  // block transfer byte grouping
  // ---------------------------------------------------------------
  // a new start clears the count so a stale partial group from an
  // aborted transfer never shortens the first group of the next one
  smbirq_chunk_cnt #(
    .CHUNK (CHUNK)
  ) u_chunk (
    .core_clk    (core_clk),
    .srst        (srst),
    .clr         (host_start),
    .step        (host_byte_done && host_block_mode),
    .chunk_pulse (chunk_evt)
  );

  // ---------------------------------------------------------------
  // slave address decode
  // ---------------------------------------------------------------
  // while either hit flag is set the slave takes no further write
  // word, so later hits are refused rather than merged
  assign alias_hit = slave_write_word && !slave_hold &&
                     (slave_dev_addr == alias_addr);
  assign slave_hit = slave_write_word && !slave_hold &&
                     (slave_dev_addr == SMBIRQ_SLAVE_ADDR);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      slave_hold <= 1'b0;
    end else begin
      slave_hold <= status_nxt[SMBIRQ_BIT_ALIAS] ||
                    status_nxt[SMBIRQ_BIT_SLAVE];
    end
  end

  // ---------------------------------------------------------------
  // event vector, one bit per status position
  // ---------------------------------------------------------------
  always_comb begin
    evt_set                   = 8'h00;
    evt_set[SMBIRQ_BIT_ERR]   = host_unclaimed ||
                                host_slave_timeout ||
                                slave_master_timeout;
    evt_set[SMBIRQ_BIT_COL]   = host_lost_arb;
    evt_set[SMBIRQ_BIT_DONE]  = host_done;
    evt_set[SMBIRQ_BIT_CHUNK] = chunk_evt;
    evt_set[SMBIRQ_BIT_SLAVE] = slave_hit;
    evt_set[SMBIRQ_BIT_ALIAS] = alias_hit;
    evt_set[SMBIRQ_BIT_ALERT] = alert_act;
  end

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  assign wr_status = reg_wr && (reg_addr == SMBIRQ_ADDR_STATUS);
  assign wr_enable = reg_wr && (reg_addr == SMBIRQ_ADDR_ENABLE);
  assign wr_mask   = reg_wr && (reg_addr == SMBIRQ_ADDR_EVT_MASK);
  assign rd_cap    = reg_rd && (reg_addr == SMBIRQ_ADDR_EVT_CAP);

  // bit 0 is not a flag and ignores the write
  assign clr_mask  = wr_status ? {reg_wdata[7:1], 1'b0} : 8'h00;

  // ---------------------------------------------------------------
  // event status flags
  // ---------------------------------------------------------------
  // a set in the cycle of its clear wins, so no event is lost;
  // flags are raised whatever the enables hold
  always_comb begin
    status_nxt = (status_r & ~clr_mask) | evt_set;
    status_nxt[SMBIRQ_BIT_PEND] = 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_r <= SMBIRQ_RST_STATUS;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ---------------------------------------------------------------
  // enable register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      enable_r <= SMBIRQ_RST_ENABLE;
    end else if (wr_enable) begin
      enable_r <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // pending flag and bus interrupt
  // ---------------------------------------------------------------
  // the alert flag is set again each cycle the synchronised pin is active, so an
  // enabled alert keeps the request up while the pin stays active
  assign pending = |(status_r[7:1] & enable_r[7:1]);

  always_comb begin
    status_view = status_r;
    status_view[SMBIRQ_BIT_PEND] = pending;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      smb_irq <= 1'b0;
    end else begin
      smb_irq <= enable_r[SMBIRQ_BIT_PEND] && pending;
    end
  end

  // ---------------------------------------------------------------
  // event capture, cleared by read, with its own mask
  // ---------------------------------------------------------------
  // alert is captured once per activation, not per cycle, so that a
  // held pin does not refill the log after every read
  logic alert_act_d_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      alert_act_d_r <= 1'b0;
    end else begin
      alert_act_d_r <= alert_act;
    end
  end

  always_comb begin
    cap_nxt = rd_cap ? 8'h00 : cap_r;
    cap_nxt = cap_nxt | evt_set;
    cap_nxt[SMBIRQ_BIT_ALERT] = (rd_cap ? 1'b0 : cap_r[SMBIRQ_BIT_ALERT]) |
                                (alert_act && !alert_act_d_r);
    cap_nxt[SMBIRQ_BIT_PEND]  = 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cap_r <= SMBIRQ_RST_EVT_CAP;
    end else begin
      cap_r <= cap_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mask_r <= SMBIRQ_RST_EVT_MASK;
    end else if (wr_mask) begin
      mask_r <= {reg_wdata[7:1], 1'b0};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      evt_irq <= 1'b0;
    end else begin
      evt_irq <= |(cap_r & mask_r);
    end
  end

  // ---------------------------------------------------------------
  // read data, valid the cycle after the strobe
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      SMBIRQ_ADDR_STATUS:   rdata_nxt = status_view;
      SMBIRQ_ADDR_ENABLE:   rdata_nxt = enable_r;
      SMBIRQ_ADDR_EVT_CAP:  rdata_nxt = cap_r;
      SMBIRQ_ADDR_EVT_MASK: rdata_nxt = mask_r;
      default:              rdata_nxt = 8'h00;
    endcase
  end

  // data is held only for the one answer cycle, zero otherwise
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // smbirq_top

/* File: test/smbirq_sva.sv */
// assertion checker for the bus interrupt status block
`timescale 1ns/10ps
module smbirq_sva
  import smbirq_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       smbus_alert_n,
  input wire logic       host_lost_arb,
  input wire logic       host_unclaimed,
  input wire logic       host_slave_timeout,
  input wire logic       host_done,
  input wire logic       slave_master_timeout,
  input wire logic       slave_write_word,
  input wire logic [6:0] slave_dev_addr,
  input wire logic [6:0] alias_addr,
  input wire logic       slave_hold,
  input wire logic       smb_irq,
  input wire logic       evt_irq
);
  // ----
  // enable shadow
  // ----
  // rebuilt from the write port so no internal probe is needed
  logic [7:0] en_q;
  logic       err_ev;
  assign err_ev = host_unclaimed | host_slave_timeout | slave_master_timeout;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      en_q <= 8'h00;
    end else if (reg_wr && reg_addr == SMBIRQ_ADDR_ENABLE) begin
      en_q <= reg_wdata;
    end
  end
  // capture mask shadow, rebuilt the same way
  logic [7:0] mk_q;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mk_q <= 8'h00;
    end else if (reg_wr && reg_addr == SMBIRQ_ADDR_EVT_MASK) begin
      mk_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // no write may move enables or clear flags in the meantime
  sequence quiet2;
    !reg_wr ##1 !reg_wr;
  endsequence
  sequence alert_held;
    (!smbus_alert_n && !reg_wr) [*4];
  endsequence
  // ----
  // assertions
  // ----
  AST_RDATA_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
  AST_EN_READ: assert property (
    reg_rd && reg_addr == SMBIRQ_ADDR_ENABLE |=> reg_rdata == $past(en_q))
    else $error("enable readback wrong");
  AST_GLOBAL_OFF: assert property (
    !$past(en_q[0]) |-> !smb_irq) else $error("irq without global enable");
  AST_NO_SOURCE: assert property (
    $past(en_q[7:1]) == 7'h00 |-> !smb_irq) else $error("irq, no source");
  AST_COL_IRQ: assert property (
    host_lost_arb && en_q[2] && en_q[0] ##0 quiet2 |-> ##1 smb_irq)
    else $error("collision gave no irq");
  AST_ERR_IRQ: assert property (
    err_ev && en_q[1] && en_q[0] ##0 quiet2 |-> ##1 smb_irq)
    else $error("device error gave no irq");
  AST_DONE_IRQ: assert property (
    host_done && en_q[3] && en_q[0] ##0 quiet2 |-> ##1 smb_irq)
    else $error("master done gave no irq");
  AST_STICKY: assert property (
    smb_irq && !reg_wr && !$past(reg_wr) |=> smb_irq)
    else $error("irq dropped without a write");
  AST_HOLD: assert property (
    slave_write_word && !slave_hold && (slave_dev_addr == SMBIRQ_SLAVE_ADDR
    || slave_dev_addr == alias_addr) |=> slave_hold)
    else $error("slave hit not flagged");
  AST_ALERT: assert property (
    alert_held ##0 (en_q[7] && en_q[0]) |-> ##[1:2] smb_irq)
    else $error("alert gave no irq");
  AST_EVT_MASK: assert property (
    $past(mk_q[7:1]) == 7'h00 |-> !evt_irq)
    else $error("event irq with empty mask");
endmodule // smbirq_sva

bind smbirq_top smbirq_sva i_smbirq_sva (
  .core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .smbus_alert_n, .host_lost_arb, .host_unclaimed, .host_slave_timeout,
  .host_done, .slave_master_timeout, .slave_write_word, .slave_dev_addr,
  .alias_addr, .slave_hold, .smb_irq, .evt_irq);

/* File: test/smbirq_partner.sv */
// model of the bus engines and devices feeding the event inputs
`timescale 1ns/10ps
module smbirq_partner (
  input  wire logic core_clk,
  output logic      smbus_alert_n,
  output logic      host_lost_arb,
  output logic      host_unclaimed,
  output logic      host_slave_timeout,
  output logic      host_start,
  output logic      host_block_mode,
  output logic      host_byte_done,
  output logic      host_done,
  output logic      slave_master_timeout,
  output logic      slave_write_word,
  output logic [6:0] slave_dev_addr
);
  logic [7:0] ev_r = 8'h00;
  initial begin
    smbus_alert_n = 1'b1;
    host_block_mode = 1'b0;
    slave_dev_addr = 7'h00;
  end
  assign {slave_write_word, slave_master_timeout, host_done, host_byte_done,
          host_start, host_slave_timeout, host_unclaimed,
          host_lost_arb} = ev_r;
  task pulse(input int k, input logic [6:0] a);
    @(posedge core_clk);
    ev_r[k] <= 1'b1;
    slave_dev_addr <= a;
    @(posedge core_clk);
    ev_r <= 8'h00;
    // address is meaningless after the word, so never leave it standing
    slave_dev_addr <= ~a;
  endtask
  task set_mode(input logic m);
    @(posedge core_clk);
    host_block_mode <= m;
  endtask
  // pulled-up line: released means high
  task set_alert(input logic lvl);
    @(posedge core_clk);
    smbus_alert_n <= lvl;
  endtask
endmodule // smbirq_partner

/* File: test/smbirq_top_bench.sv */
// self-checking bench for the bus interrupt status block
`timescale 1ns/10ps
module smbirq_top_bench;
  import smbirq_pkg::*;
  logic       core_clk = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [6:0] alias_addr = 7'h2a;
  logic [6:0] slave_dev_addr;
  logic       smbus_alert_n, host_lost_arb, host_unclaimed, host_start;
  logic       host_slave_timeout, host_block_mode, host_byte_done;
  logic       host_done, slave_master_timeout, slave_write_word;
  logic       slave_hold, smb_irq, evt_irq;
  int         bad_count = 0;
  int         n_tests = 0;
  int         ev_idx[5] = '{0, 1, 2, 6, 5};
  int         flag_bit[5] = '{2, 1, 1, 1, 3};

  always #12.5 core_clk = ~core_clk;

  smbirq_top #(.CHUNK(SMBIRQ_CHUNK_BYTES)) i_smbirq_top (
    .core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .smbus_alert_n, .host_lost_arb, .host_unclaimed, .host_slave_timeout,
    .host_start, .host_block_mode, .host_byte_done, .host_done,
    .slave_master_timeout, .slave_write_word, .slave_dev_addr, .alias_addr,
    .slave_hold, .smb_irq, .evt_irq);
  smbirq_partner i_smbirq_partner (
    .core_clk, .smbus_alert_n, .host_lost_arb, .host_unclaimed,
    .host_slave_timeout, .host_start, .host_block_mode, .host_byte_done,
    .host_done, .slave_master_timeout, .slave_write_word, .slave_dev_addr);

  // ----
  // bus and compare tasks
  // ----
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    n_tests++;
    if (reg_rdata !== exp) begin
      bad_count++;
      $display("[FAIL] %0t reg %h read %h want %h", $time, a, reg_rdata, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t pin %b want %b", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_sources;
    logic [7:0] b;
    chk_reg(SMBIRQ_ADDR_STATUS, SMBIRQ_RST_STATUS);
    chk_reg(SMBIRQ_ADDR_ENABLE, SMBIRQ_RST_ENABLE);
    chk_reg(8'h9c, 8'h00);
    chk_reg(SMBIRQ_ADDR_EVT_CAP, SMBIRQ_RST_EVT_CAP);
    chk_reg(SMBIRQ_ADDR_EVT_MASK, SMBIRQ_RST_EVT_MASK);
    for (int k = 0; k < 5; k++) begin
      b = 8'h01 << flag_bit[k];
      wr(SMBIRQ_ADDR_ENABLE, 8'h00);
      i_smbirq_partner.pulse(ev_idx[k], 7'h00);
      chk_reg(SMBIRQ_ADDR_STATUS, b);
      wr(SMBIRQ_ADDR_ENABLE, b);
      chk_reg(SMBIRQ_ADDR_STATUS, b | 8'h01);
      chk_pin(smb_irq, 1'b0);
      wr(SMBIRQ_ADDR_ENABLE, b | 8'h01);
      idle(2);
      chk_pin(smb_irq, 1'b1);
      i_smbirq_partner.pulse(ev_idx[k], 7'h00);
      // bit 0 is written too: it must be ignored
      wr(SMBIRQ_ADDR_STATUS, b | 8'h01);
      chk_reg(SMBIRQ_ADDR_STATUS, 8'h00);
      chk_pin(smb_irq, 1'b0);
    end
    $display("sources done");
  endtask
  task automatic t_slave;
    wr(SMBIRQ_ADDR_ENABLE, 8'h41);
    i_smbirq_partner.pulse(7, alias_addr);
    chk_reg(SMBIRQ_ADDR_STATUS, 8'h41);
    i_smbirq_partner.pulse(7, SMBIRQ_SLAVE_ADDR);
    chk_reg(SMBIRQ_ADDR_STATUS, 8'h41);
    wr(SMBIRQ_ADDR_STATUS, 8'h40);
    i_smbirq_partner.pulse(7, 7'h33);
    chk_reg(SMBIRQ_ADDR_STATUS, 8'h00);
    i_smbirq_partner.pulse(7, SMBIRQ_SLAVE_ADDR);
    chk_reg(SMBIRQ_ADDR_STATUS, 8'h20);
    wr(SMBIRQ_ADDR_ENABLE, 8'h21);
    idle(2);
    chk_pin(smb_irq, 1'b1);
    wr(SMBIRQ_ADDR_STATUS, 8'h20);
    $display("slave done");
  endtask
  task automatic t_chunk;
    wr(SMBIRQ_ADDR_ENABLE, 8'h11);
    i_smbirq_partner.set_mode(1'b1);
    // bytes of an aborted transfer must not count towards the next one
    repeat (3) i_smbirq_partner.pulse(4, 7'h00);
    i_smbirq_partner.pulse(3, 7'h00);
    repeat (SMBIRQ_CHUNK_BYTES - 1) i_smbirq_partner.pulse(4, 7'h00);
    chk_reg(SMBIRQ_ADDR_STATUS, 8'h00);
    i_smbirq_partner.pulse(4, 7'h00);
    idle(2);
    chk_reg(SMBIRQ_ADDR_STATUS, 8'h11);
    chk_pin(smb_irq, 1'b1);
    wr(SMBIRQ_ADDR_STATUS, 8'h10);
    i_smbirq_partner.set_mode(1'b0);
    // bytes outside block protocol never form a group
    repeat (SMBIRQ_CHUNK_BYTES) i_smbirq_partner.pulse(4, 7'h00);
    chk_reg(SMBIRQ_ADDR_STATUS, 8'h00);
    $display("chunk done");
  endtask
  task automatic t_alert;
    wr(SMBIRQ_ADDR_ENABLE, 8'h00);
    i_smbirq_partner.set_alert(1'b0);
    idle(6);
    chk_reg(SMBIRQ_ADDR_STATUS, 8'h80);
    wr(SMBIRQ_ADDR_ENABLE, 8'h81);
    idle(4);
    chk_pin(smb_irq, 1'b1);
    i_smbirq_partner.set_alert(1'b1);
    idle(3);
    wr(SMBIRQ_ADDR_STATUS, 8'h80);
    chk_reg(SMBIRQ_ADDR_STATUS, 8'h00);
    chk_pin(smb_irq, 1'b0);
    $display("alert done");
  endtask
  task automatic t_capture;
    // every earlier scenario left its event in the capture log
    chk_reg(SMBIRQ_ADDR_EVT_CAP, 8'hfe);
    wr(SMBIRQ_ADDR_EVT_CAP, 8'hff);
    chk_reg(SMBIRQ_ADDR_EVT_CAP, 8'h00);
    wr(SMBIRQ_ADDR_EVT_MASK, 8'h09);
    chk_reg(SMBIRQ_ADDR_EVT_MASK, 8'h08);
    i_smbirq_partner.pulse(0, 7'h00);
    idle(2);
    chk_pin(evt_irq, 1'b0);
    i_smbirq_partner.pulse(5, 7'h00);
    idle(2);
    chk_pin(evt_irq, 1'b1);
    chk_reg(SMBIRQ_ADDR_EVT_CAP, 8'h0c);
    idle(1);
    chk_pin(evt_irq, 1'b0);
    $display("capture done");
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_sources;
    t_slave;
    t_chunk;
    t_alert;
    t_capture;
    finish_test;
  end
  // all scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    finish_test;
  end
endmodule // smbirq_top_bench
